// ### hdl/lfs_pkg.sv
// shared constants and types of the led flash sequencer
package lfs_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 250;
  localparam int TRIG_TO_FLASH_NS = 10000;
  localparam int TRIG_OUT_LEAD_NS = 6500;
  localparam int FLASH_DELAY_CYC = TRIG_TO_FLASH_NS * CLK_MHZ / 1000;
  localparam int TRIG_OUT_LEAD_CYC = TRIG_OUT_LEAD_NS * CLK_MHZ / 1000;
  localparam int UPDATE_NS = 100000;
  localparam int UPDATE_CYC = UPDATE_NS * CLK_MHZ / 1000;
  localparam int I2C_KHZ = 400;
  localparam int I2C_QTR_CYC = (CLK_MHZ * 1000 + 4 * I2C_KHZ - 1) / (4 * I2C_KHZ);
  // pin edge reaches the counter this many cycles late
  localparam int SYNC_LAT = 3;
  // ==========================================================
  // i2c frame: start, address, ack, two data bytes, stop
  localparam int SENSORS = 4;
  localparam int I2C_LAST_SLOT = 28;
  localparam logic [6:0] SENSOR_BASE_ADDR = 7'h48;
  // 70 degrees at 7.8125 millidegree per lsb
  localparam logic [15:0] TEMP_LIMIT = 16'h2300;
  // ==========================================================
  // reset levels of the pins
  localparam logic BUCK_OFF_N = 1'b1;
  localparam logic SHUNT_OFF = 1'b0;
  typedef logic [31:0] lfs_cnt_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ARMED = 3'h2,
    ST_FLASH = 3'h4
  } lfs_state_e;
endpackage

// ### hdl/lfs_temp_if.sv
// request and result path between sequencer and temperature poller
`timescale 1ns/1ps
interface lfs_temp_if;
  logic start;
  logic [1:0] sensor;
  logic done;
  logic nack;
  logic [15:0] temp;
  modport ctrl (output start, output sensor, input done, input nack, input temp);
  modport poller (input start, input sensor, output done, output nack, output temp);
endinterface

// ### hdl/lfs_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lfs_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_q <= '1;
      sync_out <= '1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // lfs_sync

// ### hdl/lfs_i2c_poll.sv
// i2c read of one temperature sensor result
`timescale 1ns/1ps
module lfs_i2c_poll
  import lfs_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  lfs_temp_if.poller bus,
  input wire logic sda_in_s,
  output logic scl_oe_n,
  output logic sda_oe_n
);
  logic busy_q;
  logic [4:0] slot_q;
  logic [1:0] qtr_q;
  logic [7:0] div_q;
  logic [1:0] sel_q;
  logic [15:0] data_q;
  logic nack_q;
  logic done_q;
  // ==========================================================
  // bit timing: four quarters per bit at 400 kHz
  wire tick = busy_q && div_q == 8'(I2C_QTR_CYC - 1);
  wire bit_end = tick && qtr_q == 2'h3;
  wire sample = tick && qtr_q == 2'h2;
  wire in_addr = slot_q >= 5'h1 && slot_q <= 5'h8;
  wire rd_bit = (slot_q >= 5'h0a && slot_q <= 5'h11) || (slot_q >= 5'h13 && slot_q <= 5'h1a);
  // each sensor on its own address
  wire [7:0] addr_byte = {SENSOR_BASE_ADDR + 7'(sel_q), 1'b1}; // RL14
  wire [2:0] addr_idx = 3'(5'h8 - slot_q);
  wire last = slot_q == 5'(I2C_LAST_SLOT);
  wire scl_low_w = busy_q && slot_q != 5'h0 && ~qtr_q[1];
  // sda moves only in the second low quarter, or with scl high for start and stop, never together with an scl edge
  wire sda_hold = busy_q && slot_q != 5'h0 && qtr_q == 2'h0;
  wire sda_low_w = busy_q && (slot_q == 5'h0 ? qtr_q[1] : last ? qtr_q != 2'h3 :
                   in_addr ? ~addr_byte[addr_idx] : slot_q == 5'h12);
  assign bus.done = done_q;
  assign bus.nack = nack_q;
  assign bus.temp = data_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      slot_q <= 5'h0;
      qtr_q <= 2'h0;
      div_q <= 8'h0;
      sel_q <= 2'h0;
      data_q <= 16'h0000;
      nack_q <= 1'b0;
      done_q <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else begin
      done_q <= busy_q && bit_end && last;
      div_q <= (!busy_q || tick) ? 8'h0 : div_q + 8'h1;
      scl_oe_n <= ~scl_low_w;
      sda_oe_n <= sda_hold ? sda_oe_n : ~sda_low_w;
      if (!busy_q && bus.start) begin
        busy_q <= 1'b1;
        sel_q <= bus.sensor;
        slot_q <= 5'h0;
        qtr_q <= 2'h0;
        nack_q <= 1'b0;
      end else if (tick) begin
        qtr_q <= qtr_q + 2'h1;
        if (bit_end) begin
          slot_q <= slot_q + 5'h1;
          busy_q <= !last;
        end
      end
      if (sample && slot_q == 5'h9) begin
        nack_q <= sda_in_s;
      end
      if (sample && rd_bit) begin
        data_q <= {data_q[14:0], sda_in_s};
      end
    end
  end
endmodule // lfs_i2c_poll

// ### hdl/lfs_sequencer.sv
// led flash sequencer: trigger to flash timing, pin control, temperature gate
// Functional notes
// [RL1] trigger to flash fixed at 10 us; code flashes trig_delay cycles after the trigger instead
// [RL2] trigger output 6.5 us before flash
// [RL3] sequence start arms shunt and buck
// [RL4] shunt released after current dependent precharge
// [RL5] compare timing in 4 ns steps
// [RL6] buck enable low on compare, high at end
// [RL7] shunt set at start, cleared on compare
// [RL8] buck start delayed to keep flash time fixed
// [RL9] end compare: buck off, interrupt, stop, release
// [RL10] end time takes added offset
// [RL11] trigger delay configurable, must cover precharge
// [RL12] alert sampled before flash suppresses it
// [RL13] any sensor overtemperature forces led off
// [RL14] sensors polled over i2c at 400 kHz
// [RL15] one sensor read per update, rotating
// [RL16] trigger is falling edge on input
// [RL17] cancel before flash on temp, off, limit
// [RL18] triggers ignored while sequence runs
`timescale 1ns/1ps
module lfs_sequencer #(
  parameter int UPDATE_CYCLES = lfs_pkg::UPDATE_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sinking_trigger_input,
  input wire logic overtemp_alert_n,
  input wire logic flash_enable,
  input wire logic [15:0] pulse_limit,
  input wire logic pulse_count_clear,
  input wire lfs_pkg::lfs_cnt_t trig_delay,
  input wire lfs_pkg::lfs_cnt_t precharge_time,
  input wire lfs_pkg::lfs_cnt_t on_time,
  input wire lfs_pkg::lfs_cnt_t end_offset,
  input wire logic sw_buck_en_n,
  input wire logic sw_shunt,
  input wire logic display_enable,
  input wire logic i2c_sda_in,
  output logic buck_en_n,
  output logic led_shunt_switch,
  output logic trigger_out,
  output logic seq_end_irq,
  output logic seq_cancel,
  output logic seq_busy,
  output logic config_error,
  output logic [15:0] pulse_count,
  output logic over_temp,
  output logic [15:0] temp_value,
  output logic [1:0] temp_sensor,
  output logic temp_valid,
  output logic i2c_scl_out,
  output logic i2c_scl_oe_n,
  output logic i2c_sda_out,
  output logic i2c_sda_oe_n
);
  import lfs_pkg::*;

  function automatic logic reached(input lfs_cnt_t cnt, input lfs_cnt_t cmp);
    reached = cnt >= cmp;
  endfunction

  // ==========================================================
  // pin inputs
  logic trig_s;
  logic alert_s;
  logic sda_s;
  logic trig_prev_q;
  lfs_sync #(.W(3)) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .async_in({sinking_trigger_input, overtemp_alert_n, i2c_sda_in}),
    .sync_out({trig_s, alert_s, sda_s})
  );
  wire trig_fall = trig_prev_q & ~trig_s; // RL16

  // ==========================================================
  // temperature polling
  lfs_temp_if tif ();
  logic poll_start_q;
  logic poll_busy_q;
  logic [1:0] poll_idx_q;
  logic [31:0] upd_cnt_q;
  logic [SENSORS-1:0] sensor_hot_q;
  lfs_i2c_poll u_poll (
    .core_clk(core_clk),
    .reset(reset),
    .bus(tif.ctrl),
    .sda_in_s(sda_s),
    .scl_oe_n(i2c_scl_oe_n),
    .sda_oe_n(i2c_sda_oe_n)
  );
  assign i2c_scl_out = 1'b0;
  assign i2c_sda_out = 1'b0;
  assign tif.start = poll_start_q;
  assign tif.sensor = poll_idx_q;
  wire upd_wrap = upd_cnt_q == 32'(UPDATE_CYCLES - 1);
  wire temp_hot = $signed(tif.temp) > $signed(TEMP_LIMIT);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      upd_cnt_q <= 32'h0000_0000;
      poll_start_q <= 1'b0;
      poll_busy_q <= 1'b0;
      poll_idx_q <= 2'h0;
      temp_value <= 16'h0000;
      temp_sensor <= 2'h0;
      temp_valid <= 1'b0;
    end else begin
      upd_cnt_q <= upd_wrap ? 32'h0000_0000 : upd_cnt_q + 32'h0000_0001;
      poll_start_q <= upd_wrap && display_enable && !poll_busy_q; // RL15
      if (poll_start_q) begin
        poll_busy_q <= 1'b1;
      end
      temp_valid <= tif.done && !tif.nack;
      if (tif.done) begin
        poll_busy_q <= 1'b0;
        poll_idx_q <= poll_idx_q + 2'h1; // RL15
        temp_value <= tif.temp;
        temp_sensor <= poll_idx_q;
      end
    end
  end

  // one overtemperature flag per sensor, refreshed by its own reading
  for (genvar i = 0; i < SENSORS; i++) begin : g_hot
    always_ff @(posedge core_clk) begin
      if (reset) begin
        sensor_hot_q[i] <= 1'b0;
      end else if (tif.done && !tif.nack && poll_idx_q == 2'(i)) begin
        sensor_hot_q[i] <= temp_hot;
      end
    end
  end

  // ==========================================================
  // flash sequence
  lfs_state_e st_q;
  lfs_state_e st_d;
  lfs_cnt_t cnt_q;
  lfs_cnt_t buck_enable_compare_q;
  lfs_cnt_t shunt_release_compare_q;
  lfs_cnt_t sequence_end_compare_q;
  lfs_cnt_t trig_out_compare_q;
  wire hot = ~alert_s | (|sensor_hot_q); // RL12 RL13
  wire limit_hit = pulse_limit != 16'h0000 && pulse_count >= pulse_limit;
  wire seq_ok = !hot && flash_enable && !limit_hit; // RL17
  wire idle = st_q == ST_IDLE;
  wire start = idle && trig_fall && seq_ok; // RL18
  wire refuse = idle && trig_fall && !seq_ok; // RL12
  wire abort = (st_q == ST_ARMED && !seq_ok) || (st_q == ST_FLASH && hot); // RL17 RL13
  wire short_delay = trig_delay < precharge_time; // RL11
  // buck starts precharge_time before the flash, or at sequence start when trig_delay is shorter; flash time stays fixed
  wire [31:0] buck_cmp_w = short_delay ? 32'h0000_0000 : trig_delay - precharge_time; // RL8
  wire [31:0] tout_cmp_w = trig_delay > 32'(TRIG_OUT_LEAD_CYC) ?
                           trig_delay - 32'(TRIG_OUT_LEAD_CYC) : 32'h0000_0000; // RL2
  wire [31:0] end_cmp_w = trig_delay + on_time + end_offset; // RL10
  wire hit_buck = reached(cnt_q, buck_enable_compare_q);
  wire hit_flash = reached(cnt_q, shunt_release_compare_q); // RL1 RL4
  wire hit_tout = reached(cnt_q, trig_out_compare_q);
  wire end_hit = st_q == ST_FLASH && reached(cnt_q, sequence_end_compare_q); // RL9
  wire stop = end_hit || abort;
  wire run = !idle && !stop;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (start) begin
          st_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (abort) begin
          st_d = ST_IDLE;
        end else if (hit_flash) begin
          st_d = ST_FLASH;
        end
      end
      ST_FLASH: begin
        if (stop) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // pin values: buck and shunt under software control while idle, buck forced off while hot, compares while running
  wire buck_d = start || stop ? BUCK_OFF_N :
                run ? (hit_buck ? 1'b0 : buck_en_n) : // RL6 RL9
                hot ? BUCK_OFF_N : sw_buck_en_n; // RL13
  wire shunt_d = start ? 1'b1 : stop ? SHUNT_OFF :
                 run ? (hit_flash ? SHUNT_OFF : led_shunt_switch) : sw_shunt; // RL3 RL7
  wire tout_d = run && (hit_tout || trigger_out); // RL2

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= ST_IDLE;
      trig_prev_q <= 1'b1;
      cnt_q <= 32'h0000_0000;
      buck_enable_compare_q <= 32'h0000_0000;
      shunt_release_compare_q <= 32'h0000_0000;
      sequence_end_compare_q <= 32'h0000_0000;
      trig_out_compare_q <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
      trig_prev_q <= trig_s;
      if (start) begin
        cnt_q <= 32'(SYNC_LAT);
        buck_enable_compare_q <= buck_cmp_w;
        shunt_release_compare_q <= trig_delay;
        sequence_end_compare_q <= end_cmp_w;
        trig_out_compare_q <= tout_cmp_w;
      end else if (!idle) begin
        cnt_q <= cnt_q + 32'h0000_0001; // RL5
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      buck_en_n <= BUCK_OFF_N;
      led_shunt_switch <= SHUNT_OFF;
      trigger_out <= 1'b0;
      seq_end_irq <= 1'b0;
      seq_cancel <= 1'b0;
      seq_busy <= 1'b0;
      config_error <= 1'b0;
      pulse_count <= 16'h0000;
      over_temp <= 1'b0;
    end else begin
      buck_en_n <= buck_d;
      led_shunt_switch <= shunt_d;
      trigger_out <= tout_d;
      seq_end_irq <= end_hit; // RL9
      seq_cancel <= abort || refuse;
      seq_busy <= st_d != ST_IDLE;
      config_error <= short_delay; // RL11
      over_temp <= hot;
      if (end_hit) begin
        pulse_count <= pulse_count + 16'h0001;
      end else if (pulse_count_clear) begin
        pulse_count <= 16'h0000;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_start;
    st_q == ST_IDLE && trig_fall && seq_ok;
  endsequence
  sequence s_armed_pins;
    led_shunt_switch && seq_busy && !trigger_out;
  endsequence

  start_shunt_a: assert property (s_start |=> s_armed_pins) // RL7
    else $error("shunt not set at sequence start");
  buck_cmp_a: assert property ($fell(buck_en_n) && seq_busy |-> $past(cnt_q) >= buck_enable_compare_q) // RL6
    else $error("buck enabled before its compare");
  flash_time_a: assert property ($fell(led_shunt_switch) && seq_busy
      |-> $past(cnt_q) == shunt_release_compare_q && !buck_en_n) // RL1
    else $error("flash start off its fixed time");
  trig_lead_a: assert property ($rose(trigger_out) |-> $past(cnt_q) >= trig_out_compare_q
      && trig_out_compare_q == shunt_release_compare_q - 32'(TRIG_OUT_LEAD_CYC)) // RL2
    else $error("trigger output lead wrong");
  end_release_a: assert property (end_hit |=> seq_end_irq && buck_en_n && !seq_busy ##1 !seq_end_irq) // RL9
    else $error("end of sequence not handled");
  busy_ignore_a: assert property (st_q == ST_FLASH && trig_fall && !stop
      |=> st_q == ST_FLASH && cnt_q == $past(cnt_q) + 32'h0000_0001) // RL18
    else $error("trigger disturbed running sequence");
  hot_abort_a: assert property (!idle && hot |=> idle && buck_en_n && !led_shunt_switch && seq_cancel) // RL13
    else $error("overtemperature did not stop flash");
  hot_refuse_a: assert property (idle && trig_fall && hot |=> !seq_busy && seq_cancel) // RL12
    else $error("flash started while hot");
  limit_stop_a: assert property (idle && trig_fall && limit_hit |=> !seq_busy) // RL17
    else $error("flash started past pulse limit");
  poll_rotate_a: assert property (tif.done |=> poll_idx_q == $past(poll_idx_q) + 2'h1) // RL15
    else $error("sensor rotation broken");

  sequence s_before_buck;
    st_q == ST_ARMED && !abort && !hit_buck;
  endsequence
  sequence s_before_flash;
    st_q == ST_ARMED && !abort && !hit_flash;
  endsequence
  sequence s_flash_edge;
    st_q == ST_ARMED && !abort && hit_flash;
  endsequence

  buck_hold_a: assert property (s_before_buck |=> buck_en_n) // RL8
    else $error("buck enabled before its delay");
  shunt_hold_a: assert property (s_before_flash |=> led_shunt_switch && seq_busy) // RL4
    else $error("shunt released during precharge");
  flash_enter_a: assert property (s_flash_edge |=> st_q == ST_FLASH && !led_shunt_switch) // RL4
    else $error("flash not entered at shunt compare");
  cnt_step_a: assert property (s_before_flash |=> cnt_q == $past(cnt_q) + 32'h0000_0001) // RL5
    else $error("sequence counter did not step");
  stop_pins_a: assert property (stop |=> !trigger_out && !led_shunt_switch) // RL9
    else $error("pins not released at stop");
  hot_buck_a: assert property (idle && hot |=> buck_en_n) // RL13
    else $error("buck on while overtemperature");
  irq_pulse_a: assert property (seq_end_irq |=> !seq_end_irq) // RL9
    else $error("end interrupt longer than one cycle");
  pulse_inc_a: assert property (end_hit |=> pulse_count == $past(pulse_count) + 16'h0001) // RL17
    else $error("pulse count not advanced");
endmodule // lfs_sequencer

// ### verification/lfs_sensor_model.sv
// behavioural temperature sensors on the shared i2c wires
`timescale 1ns/1ps
module lfs_sensor_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [63:0] temp_tbl,
  output logic sda_rel
);
  int bit_q;
  logic [7:0] byte_q;
  logic sel_q;
  logic [15:0] word_q;
  initial begin
    sda_rel = 1'b1;
    bit_q = 99;
    sel_q = 1'b0;
    byte_q = 8'h00;
    word_q = 16'h0000;
  end
  // ==========================================================
  // start condition opens a frame
  always @(negedge sda) begin
    if (scl) begin
      bit_q = 0;
      sel_q = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (bit_q < 8) byte_q = {byte_q[6:0], sda};
    bit_q = bit_q + 1;
  end
  // ==========================================================
  // sda changes only while scl is low
  always @(negedge scl) begin
    sda_rel = 1'b1;
    if (bit_q == 8) begin
      sel_q = (byte_q[7:3] == 5'b10010) && byte_q[0];
      word_q = temp_tbl[16*byte_q[2:1] +: 16];
      if (sel_q) sda_rel = 1'b0;
    end else if (sel_q && bit_q >= 9 && bit_q <= 16) begin
      sda_rel = word_q[24 - bit_q];
    end else if (sel_q && bit_q >= 18 && bit_q <= 25) begin
      sda_rel = word_q[25 - bit_q];
    end
  end
endmodule // lfs_sensor_model

// ### verification/led_flash_sequencer_tb.sv
// self-checking bench of the led flash sequencer
`timescale 1ns/1ps
module led_flash_sequencer_tb;
  import lfs_pkg::*;
  localparam int UPD = 50;
  logic core_clk = 1'b0, reset = 1'b1, trig_pin = 1'b1, alert_n = 1'b1, fl_en = 1'b1;
  logic cnt_clr = 1'b0, disp_en = 1'b0, sw_buck_n = 1'b1, sw_sh = 1'b1;
  logic [15:0] plimit = 16'h0000;
  lfs_cnt_t tdelay = 32'h0000_09c4, pre = 32'h0000_0190, ontime = 32'h0000_0064;
  lfs_cnt_t eoff = 32'h0000_0000;
  logic buck_n, shunt, tout, irq, cancel, busy, cfg_err, hot, tvalid, scl_oe_n, sda_oe_n;
  logic sda_rel;
  logic [15:0] pcount, tval;
  logic [1:0] tsens;
  logic [15:0] temps [4];
  wire scl_w = scl_oe_n;
  wire sda_w = sda_oe_n & sda_rel;
  int fail_count = 0, total_checks = 0;
  initial temps = '{16'h1000, 16'h2400, 16'h0100, 16'h0800};
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  lfs_sequencer #(.UPDATE_CYCLES(UPD)) dut_u (
    .core_clk(core_clk), .reset(reset), .sinking_trigger_input(trig_pin),
    .overtemp_alert_n(alert_n), .flash_enable(fl_en), .pulse_limit(plimit),
    .pulse_count_clear(cnt_clr), .trig_delay(tdelay), .precharge_time(pre),
    .on_time(ontime), .end_offset(eoff), .sw_buck_en_n(sw_buck_n), .sw_shunt(sw_sh),
    .display_enable(disp_en), .i2c_sda_in(sda_w), .buck_en_n(buck_n),
    .led_shunt_switch(shunt), .trigger_out(tout), .seq_end_irq(irq), .seq_cancel(cancel),
    .seq_busy(busy), .config_error(cfg_err), .pulse_count(pcount), .over_temp(hot),
    .temp_value(tval), .temp_sensor(tsens), .temp_valid(tvalid), .i2c_scl_out(),
    .i2c_scl_oe_n(scl_oe_n), .i2c_sda_out(), .i2c_sda_oe_n(sda_oe_n));
  lfs_sensor_model part_u (.scl(scl_w), .sda(sda_w),
    .temp_tbl({temps[3], temps[2], temps[1], temps[0]}), .sda_rel(sda_rel));
  // ==========================================================
  // shared helpers
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask
  // ==========================================================
  // one flash, with two more falling trigger edges while it runs, one before the flash and one during it
  task automatic flash_run(lfs_cnt_t d, lfs_cnt_t p, lfs_cnt_t o, lfs_cnt_t e);
    int nb, nbk, nto, nsh, nirq;
    logic [15:0] c0;
    nb = 0; nbk = 0; nto = 0; nsh = 0; nirq = 0;
    @(posedge core_clk) {tdelay, pre, ontime, eoff} <= {d, p, o, e};
    c0 = pcount;
    tick(3);
    @(posedge core_clk) trig_pin <= 1'b0;
    for (int n = 1; n < d + o + e + 40; n++) begin
      @(posedge core_clk);
      if (n == 10 || n == 30) trig_pin <= 1'b1;
      if (n == 20) trig_pin <= 1'b0;
      if (n == d + 4) trig_pin <= 1'b0;
      if (n == d + 8) trig_pin <= 1'b1;
      #1;
      if (busy === 1'b1 && nb == 0) nb = n;
      if (n == 4) chk("shunt_at_start", 1, shunt);
      if (buck_n === 1'b0 && nbk == 0) nbk = n;
      if (tout === 1'b1 && nto == 0) nto = n;
      if (nb != 0 && shunt === 1'b0 && nsh == 0) nsh = n;
      if (irq === 1'b1 && nirq == 0) nirq = n;
      if (nirq != 0 && n == nirq + 1) chk("pins_to_sw", {sw_buck_n, sw_sh}, {buck_n, shunt});
    end
    chk("busy_rise", 3, nb);
    chk("buck_on", d - p + 1, nbk);
    chk("flash_start", d + 1, nsh);
    chk("trigger_out", d - 1625 + 1, nto);
    chk("seq_end", d + o + e + 1, nirq);
    chk("no_restart", 0, busy);
    chk("count_inc", c0 + 16'h0001, pcount);
  endtask
  // ==========================================================
  // trigger refused: 0 off flag, 1 alert, 2 count limit
  task automatic cancel_run(int mode);
    int nc, nbz;
    nc = 0; nbz = 0;
    @(posedge core_clk) sw_buck_n <= 1'b0;
    if (mode == 0) fl_en <= 1'b0;
    if (mode == 1) alert_n <= 1'b0;
    if (mode == 2) plimit <= pcount;
    tick(5);
    @(posedge core_clk) trig_pin <= 1'b0;
    repeat (12) begin
      @(posedge core_clk);
      #1;
      if (cancel === 1'b1) nc++;
      if (busy !== 1'b0) nbz++;
    end
    chk("cancel_pulse", 1, nc);
    chk("no_start", 0, nbz);
    chk("buck_off", mode == 1, buck_n);
    @(posedge core_clk) {trig_pin, fl_en, alert_n, sw_buck_n, plimit} <= {4'b1111, 16'h0000};
    tick(5);
  endtask
  // ==========================================================
  // alert while armed, before the buck starts precharge, aborts, buck off and shunt back to software
  task automatic abort_run();
    int nc;
    nc = 0;
    @(posedge core_clk) trig_pin <= 1'b0;
    for (int n = 1; n < 30; n++) begin
      @(posedge core_clk);
      if (n == 10) alert_n <= 1'b0;
      #1;
      if (cancel === 1'b1) nc++;
    end
    chk("abort_cancel", 1, nc);
    chk("abort_pins", {1'b1, sw_sh, 1'b0}, {buck_n, shunt, busy});
    @(posedge core_clk) {trig_pin, alert_n, cnt_clr} <= 3'b111;
    @(posedge core_clk) cnt_clr <= 1'b0;
    #1;
    chk("count_clear", 0, pcount);
    tick(5);
  endtask
  task automatic config_run();
    @(posedge core_clk) {tdelay, pre} <= {32'h0000_0064, 32'h0000_00c8};
    tick(3);
    #1;
    chk("cfg_err_set", 1, cfg_err);
    @(posedge core_clk) pre <= 32'h0000_0032;
    tick(3);
    #1;
    chk("cfg_err_clr", 0, cfg_err);
  endtask
  // ==========================================================
  // three polls over i2c, one sensor each, rotating
  task automatic poll_run();
    logic [1:0] prev;
    int w;
    prev = 2'h3;
    @(posedge core_clk) disp_en <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      w = 0;
      do begin
        @(posedge core_clk);
        #1;
        w++;
      end while (tvalid !== 1'b1 && w < 20000);
      if (w >= 20000) begin
        chk("poll_timeout", 1, 0);
        finish_test();
      end
      chk("poll_sensor", 2'(prev + 2'h1), tsens);
      chk("poll_value", temps[2'(prev + 2'h1)], tval);
      if (k != 1) chk("over_temp", k == 2, hot);
      prev = tsens;
    end
  endtask
  initial begin
    tick(1);
    #1;
    chk("reset_pins", 3'b100, {buck_n, shunt, busy});
    tick(1);
    reset <= 1'b0;
    tick(3);
    flash_run(32'h0000_09c4, 32'h0000_0190, 32'h0000_0064, 32'h0000_0014);
    flash_run(32'h0000_07d0, 32'h0000_03e8, 32'h0000_0032, 32'h0000_0000);
    for (int m = 0; m < 3; m++) cancel_run(m);
    abort_run();
    config_run();
    poll_run();
    finish_test();
  end
endmodule // led_flash_sequencer_tb
